// file: rtl/pmicr_pkg.sv
// Constants and types for the management crossover register bank
package pmicr_pkg;

  // ==========================================================
  // Management register addresses
  localparam logic [4:0] ADDR_EXT_ABILITY = 5'h0f;
  localparam logic [4:0] ADDR_IND_PTR = 5'h10;
  localparam logic [4:0] ADDR_IND_DATA = 5'h11;
  localparam logic [4:0] ADDR_XOVER_CTRL = 5'h12;

  // ==========================================================
  // Reset values
  localparam logic [15:0] RST_EXT_ABILITY = 16'h0000;
  localparam logic [15:0] RST_IND_PTR = 16'h0000;
  localparam logic [15:0] RST_IND_DATA = 16'h0000;
  localparam logic [15:0] RST_XOVER_CTRL = 16'h0002;

  // ==========================================================
  // Control register fields
  localparam int unsigned BIT_AUTO_EN = 10;
  localparam int unsigned BIT_MAN_XOVER = 9;
  localparam int unsigned BIT_DIAG_CLK = 2;
  localparam logic [15:0] XOVER_CTRL_WMASK = 16'h0607;

  // ==========================================================
  // Management frame fields
  localparam logic [5:0] PREAMBLE_LEN = 6'h20;
  localparam logic [5:0] HDR_BITS = 6'h0d;
  localparam logic [5:0] WR_TAIL_BITS = 6'h12;
  localparam logic [5:0] RD_DATA_BITS = 6'h10;
  localparam logic [1:0] C22_OP_WRITE = 2'h1;
  localparam logic [1:0] C22_OP_READ = 2'h2;
  localparam logic [1:0] C45_OP_ADDR = 2'h0;
  localparam logic [1:0] C45_OP_WRITE = 2'h1;
  localparam logic [1:0] C45_OP_READ_INC = 2'h2;
  localparam logic [1:0] C45_OP_READ = 2'h3;

  // ==========================================================
  // Frame engine states
  typedef enum logic [2:0] {
    ST_PRE = 3'b000,
    ST_HDR = 3'b001,
    ST_RTA = 3'b010,
    ST_RDAT = 3'b011,
    ST_WDAT = 3'b100
  } pmicr_state_e;

endpackage : pmicr_pkg

// file: rtl/pmicr_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module pmicr_sync #(
  parameter int unsigned WIDTH = 1
) (
  // Clock
  input wire logic clk,
  // Asynchronous inputs and synchronised outputs
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } pmicr_sync_s;

  pmicr_sync_s r;
  pmicr_sync_s d;

  always_comb
  begin
    d.s1 = async_in;
    d.s2 = r.s1;
  end

  always_ff @(posedge clk)
  begin
    r <= d;
  end

  assign sync_out = r.s2;

endmodule : pmicr_sync

// file: rtl/pmicr_ext_space.sv
// Extended register space storage
`timescale 1ns/1ps
module pmicr_ext_space #(
  parameter int unsigned AW = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Access port
  input wire logic we,
  input wire logic [15:0] addr,
  input wire logic [15:0] wdata,
  output logic [15:0] rdata
);

  typedef struct packed {
    logic [(1<<AW)-1:0][15:0] mem;
  } pmicr_ext_s;

  pmicr_ext_s r;
  pmicr_ext_s d;
  logic in_range;

  // Addresses beyond the implemented words read zero and drop writes
  assign in_range = (addr[15:AW] == '0);
  assign rdata = in_range ? r.mem[addr[AW-1:0]] : 16'h0000;

  always_comb
  begin
    d = r;
    if (!rst_n)
    begin
      d.mem = '0;
    end
    else if (we && in_range)
    begin
      d.mem[addr[AW-1:0]] = wdata;
    end
  end

  always_ff @(posedge clk)
  begin
    r <= d;
  end

endmodule : pmicr_ext_space

// file: rtl/pmicr_top.sv
// Management serial slave with extended status, indirect window and crossover control
// What this block does
// - Extended ability status reads zero in its gigabit bits 15..12 and reserved bits 11..0.
// - Extended ability status sits at address 0x0F, read-only, value 0x0000 after reset.
// - Reading the data window returns the pointed extended register; writing it updates that one.
// - Every extended register is also reachable directly by Clause 45 frames.
// - The indirect address pointer is a 16-bit read/write register at 0x10, reset 0x0000.
// - The indirect data window is a 16-bit read/write register at 0x11, reset 0x0000.
// - With auto-enable (bit 10) set, crossover resolves automatically, preferring MDIX when bit 9 is 1.
// - The auto-enable reset default comes from a hardware strap.
// - With auto-enable clear and bit 9 set, pairs map straight through (MDIX, no swap).
// - With auto-enable clear and bit 9 clear, pairs are swapped (MDI).
// - Bit 2 gates the diagnostics clock; it drives the diag_clk_enable output.
// - The control register is at 0x12, resets to 0x0002 with bit 10 then loaded from the strap, bits 10..9 and 2..0 are read/write, others read zero.
`timescale 1ns/1ps
module pmicr_top
  import pmicr_pkg::*;
#(
  parameter logic [4:0] PHY_ADDR = 5'h00,
  parameter logic [4:0] MMD_DEVAD = 5'h1e,
  parameter int unsigned EXT_AW = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Management serial pins
  input wire logic mdc,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe,
  // Hardware strap
  input wire logic auto_xover_strap,
  // Crossover resolution from the on-chip detector
  input wire logic auto_resolved_mdix,
  // Crossover and diagnostics controls
  output logic xover_auto_enable,
  output logic xover_prefer_mdix,
  output logic pair_swap,
  output logic diag_clk_enable
);

  // ==========================================================
  // State
  typedef struct packed {
    pmicr_state_e st;
    logic [5:0] cnt;
    logic [12:0] hdr;
    logic [17:0] wsh;
    logic [15:0] rsh;
    logic mdc_prev;
    logic hit;
    logic c45;
    logic [15:0] ptr;
    logic [15:0] mmd_addr;
    logic [15:0] ctrl;
    logic strap_pend;
    logic mdio_o;
    logic mdio_oe;
    logic auto_en;
    logic prefer_mdix;
    logic pair_swap;
    logic diag_clk;
  } pmicr_regs_s;

  pmicr_regs_s r;
  pmicr_regs_s d;

  // ==========================================================
  // Pin synchronisers
  logic [2:0] pins_s;
  logic mdc_s;
  logic mdio_s;
  logic strap_s;

  pmicr_sync #(
    .WIDTH(3)
  ) u_sync (
    .clk(clk),
    .async_in({auto_xover_strap, mdio_i, mdc}),
    .sync_out(pins_s)
  );

  assign mdc_s = pins_s[0];
  assign mdio_s = pins_s[1];
  assign strap_s = pins_s[2];

  // ==========================================================
  // Extended register space
  logic ext_we;
  logic [15:0] ext_addr;
  logic [15:0] ext_wdata;
  logic [15:0] ext_rdata;

  pmicr_ext_space #(
    .AW(EXT_AW)
  ) u_ext (
    .clk(clk),
    .rst_n(rst_n),
    .we(ext_we),
    .addr(ext_addr),
    .wdata(ext_wdata),
    .rdata(ext_rdata)
  );

  // ==========================================================
  // Clause 22 read decode
  function automatic logic [15:0] c22_read(
    input logic [4:0] regad,
    input logic [15:0] ptr,
    input logic [15:0] ctrl,
    input logic [15:0] ext
  );
    logic [15:0] v;
    v = 16'h0000;
    case (regad)
      ADDR_EXT_ABILITY: v = RST_EXT_ABILITY;
      ADDR_IND_PTR: v = ptr;
      ADDR_IND_DATA: v = ext;
      ADDR_XOVER_CTRL: v = ctrl & XOVER_CTRL_WMASK;
      default: v = 16'h0000;
    endcase
    return v;
  endfunction : c22_read

  // ==========================================================
  // Frame engine
  logic rise;
  logic [12:0] hdr_n;
  logic [17:0] wsh_n;
  logic hdr_c45;
  logic [1:0] hdr_op;
  logic hdr_hit;
  logic [15:0] rd_val;

  assign rise = mdc_s && !r.mdc_prev;
  assign hdr_n = {r.hdr[11:0], mdio_s};
  assign wsh_n = {r.wsh[16:0], mdio_s};
  assign hdr_c45 = !hdr_n[12];
  assign hdr_op = hdr_n[11:10];
  assign hdr_hit = (hdr_n[9:5] == PHY_ADDR) && (!hdr_c45 || hdr_n[4:0] == MMD_DEVAD);

  // Window and direct frames share one storage port
  always_comb
  begin
    ext_addr = ((r.st == ST_HDR) ? hdr_c45 : r.c45) ? r.mmd_addr : r.ptr;
  end

  always_comb
  begin
    rd_val = hdr_c45 ? ext_rdata : c22_read(hdr_n[4:0], r.ptr, r.ctrl, ext_rdata);
  end

  always_comb
  begin
    d = r;
    ext_we = 1'b0;
    ext_wdata = wsh_n[15:0];
    d.mdc_prev = mdc_s;
    if (!rst_n)
    begin
      d.st = ST_PRE;
      d.cnt = 6'h00;
      d.hdr = '0;
      d.wsh = '0;
      d.rsh = '0;
      d.mdc_prev = mdc_s;
      d.hit = 1'b0;
      d.c45 = 1'b0;
      d.ptr = RST_IND_PTR;
      d.mmd_addr = RST_IND_DATA;
      d.ctrl = RST_XOVER_CTRL;
      d.strap_pend = 1'b1;
      d.mdio_o = 1'b0;
      d.mdio_oe = 1'b0;
    end
    else
    begin
      if (r.strap_pend)
      begin
        d.ctrl[BIT_AUTO_EN] = strap_s;
        d.strap_pend = 1'b0;
      end
      if (rise)
      begin
        case (r.st)
          ST_PRE:
          begin
            if (mdio_s)
            begin
              d.cnt = (r.cnt == PREAMBLE_LEN) ? r.cnt : r.cnt + 6'h01;
            end
            else if (r.cnt == PREAMBLE_LEN)
            begin
              d.st = ST_HDR;
              d.cnt = 6'h00;
            end
            else
            begin
              d.cnt = 6'h00;
            end
          end
          ST_HDR:
          begin
            d.hdr = hdr_n;
            d.cnt = r.cnt + 6'h01;
            if (r.cnt == HDR_BITS - 6'h01)
            begin
              d.cnt = 6'h00;
              d.c45 = hdr_c45;
              d.hit = 1'b0;
              d.st = ST_WDAT;
              if (hdr_hit && !hdr_c45 && hdr_op == C22_OP_READ)
              begin
                d.rsh = rd_val;
                d.st = ST_RTA;
              end
              else if (hdr_hit && hdr_c45 &&
                       (hdr_op == C45_OP_READ || hdr_op == C45_OP_READ_INC))
              begin
                d.rsh = rd_val;
                d.st = ST_RTA;
                if (hdr_op == C45_OP_READ_INC)
                begin
                  d.mmd_addr = r.mmd_addr + 16'h0001;
                end
              end
              else if (hdr_hit && (hdr_c45 || hdr_op == C22_OP_WRITE))
              begin
                d.hit = 1'b1;
              end
            end
          end
          ST_RTA:
          begin
            d.mdio_oe = 1'b1;
            d.mdio_o = 1'b0;
            d.st = ST_RDAT;
            d.cnt = 6'h00;
          end
          ST_RDAT:
          begin
            if (r.cnt == RD_DATA_BITS)
            begin
              d.mdio_oe = 1'b0;
              d.mdio_o = 1'b0;
              d.st = ST_PRE;
              d.cnt = 6'h00;
            end
            else
            begin
              d.mdio_o = r.rsh[15];
              d.rsh = {r.rsh[14:0], 1'b0};
              d.cnt = r.cnt + 6'h01;
            end
          end
          ST_WDAT:
          begin
            d.wsh = wsh_n;
            d.cnt = r.cnt + 6'h01;
            if (r.cnt == WR_TAIL_BITS - 6'h01)
            begin
              d.st = ST_PRE;
              d.cnt = 6'h00;
              if (r.hit && r.c45)
              begin
                if (r.hdr[11:10] == C45_OP_ADDR)
                begin
                  d.mmd_addr = wsh_n[15:0];
                end
                else if (r.hdr[11:10] == C45_OP_WRITE)
                begin
                  ext_we = 1'b1;
                end
              end
              else if (r.hit)
              begin
                case (r.hdr[4:0])
                  ADDR_IND_PTR: d.ptr = wsh_n[15:0];
                  ADDR_IND_DATA: ext_we = 1'b1;
                  ADDR_XOVER_CTRL:
                    d.ctrl = wsh_n[15:0] & XOVER_CTRL_WMASK;
                  default: d.ptr = r.ptr;
                endcase
              end
            end
          end
          default:
          begin
            d.st = ST_PRE;
            d.cnt = 6'h00;
            d.mdio_oe = 1'b0;
          end
        endcase
      end
    end
    // Crossover and diagnostic outputs follow the next control value
    d.auto_en = d.ctrl[BIT_AUTO_EN];
    d.prefer_mdix = d.ctrl[BIT_MAN_XOVER];
    if (d.ctrl[BIT_AUTO_EN])
    begin
      d.pair_swap = !auto_resolved_mdix;
    end
    else
    begin
      d.pair_swap = !d.ctrl[BIT_MAN_XOVER];
    end
    d.diag_clk = d.ctrl[BIT_DIAG_CLK];
  end

  always_ff @(posedge clk)
  begin
    r <= d;
  end

  // ==========================================================
  // Outputs
  assign mdio_o = r.mdio_o;
  assign mdio_oe = r.mdio_oe;
  assign xover_auto_enable = r.auto_en;
  assign xover_prefer_mdix = r.prefer_mdix;
  assign pair_swap = r.pair_swap;
  assign diag_clk_enable = r.diag_clk;

endmodule : pmicr_top

// file: bench/pmicr_top_sva.sv
// Pin checks for the crossover register bank
`timescale 1ns/1ps
module pmicr_top_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Management pins
  input wire logic mdc,
  input wire logic mdio_i,
  input wire logic mdio_o,
  input wire logic mdio_oe,
  // Strap, detector and controls
  input wire logic auto_xover_strap,
  input wire logic auto_resolved_mdix,
  input wire logic xover_auto_enable,
  input wire logic xover_prefer_mdix,
  input wire logic pair_swap,
  input wire logic diag_clk_enable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ====
  // Checks
  swap_manual_a: assert property (
    !xover_auto_enable && $stable(xover_auto_enable) && $stable(xover_prefer_mdix)
    |-> pair_swap == !xover_prefer_mdix) else $error("manual swap wrong");
  swap_auto_a: assert property (
    xover_auto_enable && $past(xover_auto_enable)
    |-> pair_swap == !$past(auto_resolved_mdix)) else $error("auto swap wrong");
  ctrl_hold_a: assert property (
    $stable(mdc) [*8] |-> $stable(diag_clk_enable) && $stable(xover_prefer_mdix))
    else $error("control moved while idle");
  oe_idle_a: assert property ($stable(mdc) [*8] |-> !mdio_oe)
    else $error("drive while idle");
  ta_zero_a: assert property ($rose(mdio_oe) |-> !mdio_o ##1 mdio_oe [*8])
    else $error("turnaround wrong");
  drive_on_rise_a: assert property (
    $changed(mdio_o) || $changed(mdio_oe) |-> $past(mdc, 2)) else $error("drive off rise");
  o_quiet_a: assert property ($changed(mdio_o) |-> mdio_oe || $past(mdio_oe))
    else $error("data moved undriven");
  strap_load_a: assert property (
    $rose(rst_n) |-> ##2 xover_auto_enable == auto_xover_strap) else $error("strap lost");
  cover property ($rose(mdio_oe));
  cover property (xover_auto_enable && !pair_swap);
  cover property ($fell(pair_swap) && !xover_auto_enable);
endmodule : pmicr_top_sva

bind pmicr_top pmicr_top_sva i_sva (.clk(clk), .rst_n(rst_n), .mdc(mdc), .mdio_i(mdio_i),
  .mdio_o(mdio_o), .mdio_oe(mdio_oe), .auto_xover_strap(auto_xover_strap),
  .auto_resolved_mdix(auto_resolved_mdix), .xover_auto_enable(xover_auto_enable),
  .xover_prefer_mdix(xover_prefer_mdix), .pair_swap(pair_swap),
  .diag_clk_enable(diag_clk_enable));

// file: bench/pmicr_host_model.sv
// Station management host issuing management frames
`timescale 1ns/1ps
module pmicr_host_model
  import pmicr_pkg::*;
(
  // Line and host drive
  input wire logic mdio_line,
  output logic mdc,
  output logic host_d,
  output logic host_oe
);
  initial
  begin
    mdc = 1'b1;
    host_d = 1'b1;
    host_oe = 1'b0;
  end
  // ====
  // One period, line sampled just before the rise
  task automatic cyc(input logic d, input logic drv, output logic s);
    mdc = 1'b0;
    host_oe = drv;
    host_d = d;
    #50;
    s = mdio_line;
    mdc = 1'b1;
    #50;
  endtask : cyc
  task automatic frame(input logic c22, input logic [1:0] op, input logic [4:0] pa,
    input logic [4:0] ra, input logic [15:0] wd, output logic [15:0] rd);
    logic s;
    logic rdx;
    logic [13:0] h;
    logic [17:0] w;
    h = {1'b0, c22, op, pa, ra};
    w = {2'b10, wd};
    rdx = c22 ? (op == C22_OP_READ) : op[1];
    rd = 16'h0000;
    for (int i = 0; i < 32; i++)
      cyc(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--)
      cyc(h[i], 1'b1, s);
    for (int i = 0; i < 18; i++)
    begin
      cyc(rdx | w[17-i], !rdx, s);
      if (i >= 2)
        rd[17-i] = s;
    end
    host_oe = 1'b0;
  endtask : frame
endmodule : pmicr_host_model

// file: bench/test_pmicr_top.sv
// Self-checking bench for the crossover register bank
`timescale 1ns/1ps
module test_pmicr_top
  import pmicr_pkg::*;
;
  localparam logic [4:0] DEVAD = 5'h1e;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic strap = 1'b0;
  logic arm = 1'b0;
  logic mdc, host_d, host_oe, mdio_o, mdio_oe, auto_en, prefer, swap, diag;
  logic [15:0] rv;
  int err_total = 0;
  int checked = 0;
  wire logic mdio_line = (mdio_oe === 1'b1) ? mdio_o : (host_oe ? host_d : 1'b1);
  always #5 clk = ~clk;
  pmicr_top #(.PHY_ADDR(5'h00), .MMD_DEVAD(DEVAD)) i_dut (.clk(clk), .rst_n(rst_n),
    .mdc(mdc), .mdio_i(mdio_line), .mdio_o(mdio_o), .mdio_oe(mdio_oe),
    .auto_xover_strap(strap), .auto_resolved_mdix(arm), .xover_auto_enable(auto_en),
    .xover_prefer_mdix(prefer), .pair_swap(swap), .diag_clk_enable(diag));
  pmicr_host_model i_host (.mdio_line(mdio_line), .mdc(mdc), .host_d(host_d),
    .host_oe(host_oe));
  // ====
  // Shared tasks
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  task automatic do_reset(input logic s);
    @(posedge clk);
    #1;
    rst_n = 1'b0;
    strap = s;
    repeat (3) @(posedge clk);
    #1;
    rst_n = 1'b1;
    repeat (4) @(posedge clk);
    #1;
  endtask : do_reset
  task automatic rd(input logic [4:0] ra);
    i_host.frame(1'b1, C22_OP_READ, 5'h00, ra, 16'h0000, rv);
    #100;
  endtask : rd
  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    i_host.frame(1'b1, C22_OP_WRITE, 5'h00, ra, d, rv);
    #100;
  endtask : wr
  task automatic c45(input logic [1:0] op, input logic [15:0] d);
    i_host.frame(1'b0, op, 5'h00, DEVAD, d, rv);
    #100;
  endtask : c45
  // ====
  // Scenarios
  task automatic t_reset_values();
    rd(ADDR_IND_PTR);
    chk(rv, 16'h0000);
    rd(ADDR_IND_DATA);
    chk(rv, 16'h0000);
    rd(ADDR_XOVER_CTRL);
    chk(rv, 16'h0002);
    chk(16'({auto_en, prefer, swap, diag}), 16'h0002);
  endtask : t_reset_values
  task automatic t_status_ro();
    wr(ADDR_EXT_ABILITY, 16'hffff);
    rd(ADDR_EXT_ABILITY);
    chk(rv, 16'h0000);
    wr(ADDR_IND_PTR, 16'h0009);
    // Frame for another station address must be ignored
    i_host.frame(1'b1, C22_OP_WRITE, 5'h01, ADDR_IND_PTR, 16'h0004, rv);
    #100;
    rd(ADDR_IND_PTR);
    chk(rv, 16'h0009);
  endtask : t_status_ro
  task automatic t_crossover();
    wr(ADDR_XOVER_CTRL, 16'hffff);
    rd(ADDR_XOVER_CTRL);
    chk(rv, 16'h0607);
    chk(16'({auto_en, prefer, swap, diag}), 16'h000f);
    arm = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk(16'(swap), 16'h0000);
    wr(ADDR_XOVER_CTRL, 16'h0203);
    chk(16'({auto_en, prefer, swap, diag}), 16'h0004);
    wr(ADDR_XOVER_CTRL, 16'h0007);
    chk(16'({auto_en, prefer, swap, diag}), 16'h0003);
    rd(ADDR_XOVER_CTRL);
    chk(rv, 16'h0007);
  endtask : t_crossover
  task automatic t_indirect();
    wr(ADDR_IND_PTR, 16'h0003);
    wr(ADDR_IND_DATA, 16'ha5c3);
    rd(ADDR_IND_PTR);
    chk(rv, 16'h0003);
    rd(ADDR_IND_DATA);
    chk(rv, 16'ha5c3);
    c45(C45_OP_ADDR, 16'h0003);
    c45(C45_OP_READ, 16'h0000);
    chk(rv, 16'ha5c3);
    c45(C45_OP_ADDR, 16'h0005);
    c45(C45_OP_WRITE, 16'h5a3c);
    wr(ADDR_IND_PTR, 16'h0005);
    rd(ADDR_IND_DATA);
    chk(rv, 16'h5a3c);
    // Read with post-increment, then plain read of the next word
    c45(C45_OP_ADDR, 16'h0004);
    c45(C45_OP_READ_INC, 16'h0000);
    chk(rv, 16'h0000);
    c45(C45_OP_READ, 16'h0000);
    chk(rv, 16'h5a3c);
    rd(ADDR_IND_PTR);
    chk(rv, 16'h0005);
  endtask : t_indirect
  task automatic t_strap();
    do_reset(1'b1);
    rd(ADDR_XOVER_CTRL);
    chk(rv, 16'h0402);
    chk(16'({auto_en, prefer, swap, diag}), 16'h0008);
  endtask : t_strap
  initial
  begin
    do_reset(1'b0);
    t_reset_values();
    t_status_ro();
    t_crossover();
    t_indirect();
    t_strap();
    tally_and_finish();
  end
  initial
  begin
    #400000;
    err_total++;
    tally_and_finish();
  end
endmodule : test_pmicr_top
